// ==== gpas_pkg.sv ====
// ============================================================
// Shared constants of the general-purpose port block
package gpas_pkg;

    // ========================================================
    // Bus and bank geometry
    localparam int          NUM_BANKS  = 5;
    localparam int          BANK_W     = 8;
    localparam int          ADDR_W     = 5;
    localparam int          DATA_W     = 8;

    // ========================================================
    // Register offsets: bank b sits at b*4 + kind
    localparam logic [1:0]  KIND_PINS  = 2'h0;
    localparam logic [1:0]  KIND_HOLD  = 2'h1;
    localparam logic [1:0]  KIND_DIR   = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_CONV_CFG = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_CMP_CFG  = 5'h15;

    // ========================================================
    // Implemented pins of each bank
    localparam logic [BANK_W-1:0] FIRST_BANK_MASK = 8'h2F;
    localparam logic [BANK_W-1:0] FULL_BANK_MASK  = 8'hFF;

    // ========================================================
    // Reset values
    localparam logic [BANK_W-1:0] DIR_RESET   = 8'hFF;
    localparam logic [BANK_W-1:0] HOLD_RESET  = 8'h00;
    localparam logic [3:0]  CONV_PORT_RESET   = 4'h0;
    localparam logic [1:0]  CONV_REF_RESET    = 2'h0;
    localparam logic [2:0]  CMP_MODE_RESET    = 3'h0;

    // ========================================================
    // Converter configuration layout
    localparam int          CONV_PORT_LSB = 0;
    localparam int          CONV_REF_LSB  = 4;
    localparam logic [3:0]  ANALOG_CHANNELS = 4'h5;

    // ========================================================
    // Comparator configuration layout and modes
    localparam int          CMP_MODE_LSB  = 0;
    localparam int          CMP_SWAP_BIT  = 3;
    localparam int          CMP_INV1_BIT  = 4;
    localparam int          CMP_INV2_BIT  = 5;
    localparam int          CMP_RES1_BIT  = 6;
    localparam int          CMP_RES2_BIT  = 7;
    localparam logic [2:0]  CMP_MODE_OFF  = 3'h7;
    localparam logic [2:0]  CMP_MODE_OUT2 = 3'h6;

    // ========================================================
    // Pin positions of the first bank
    localparam int          PIN0 = 0;
    localparam int          PIN1 = 1;
    localparam int          PIN2 = 2;
    localparam int          PIN3 = 3;
    localparam int          PIN5 = 5;

endpackage

// ==== gpas_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// One port bank: direction and output-hold storage
module gpas_bank (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Bank shape
    input  wire logic        present,
    input  wire logic [7:0]  impl_mask,
    // Register writes
    input  wire logic        wr_hold,
    input  wire logic        wr_dir,
    input  wire logic [7:0]  wdata,
    // Stored state
    output logic      [7:0]  dir_r,
    output logic      [7:0]  hold_r
);

    // Direction bits, all inputs after reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dir_r <= gpas_pkg::DIR_RESET;
        end else if (wr_dir && present) begin
            dir_r <= (wdata & impl_mask) | ~impl_mask;
        end
    end

    // Output-hold bits, written directly or through the pin register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_r <= gpas_pkg::HOLD_RESET;
        end else if (wr_hold && present) begin
            hold_r <= wdata & impl_mask;
        end
    end

endmodule
`default_nettype wire

// ==== gpas_port.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Up to five banks, present per variant
// - Direction, pin-level and output-hold registers
// - Output-hold reads return held value, not pins
// - First bank five pins wide
// - Direction one: driver high impedance
// - Direction zero: drive output-hold bit
// - Pin read gives pins; write goes hold
// - Enabled peripheral takes over shared pin
// - Converter config selects analog or digital pins
// - Comparator config claims pins 0,3; drives pin 5 in mode 6 only
// - After reset shared pins analog, read zero
// - Direction still gates drivers on analog pins
module gpas_port (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_r,
    // Variant and feature straps, one bit per bank
    input  wire logic [4:0]  bank_present,
    // Pins of all banks, eight per bank
    input  wire logic [39:0] pad_in,
    output logic      [39:0] pad_out_r,
    output logic      [39:0] pad_oe_r,
    // Comparator results from the analog block
    input  wire logic [1:0]  cmp_result,
    // Configuration towards converter and comparators
    output logic      [4:0]  analog_sel_r,
    output logic      [1:0]  conv_ref_cfg_r,
    output logic      [2:0]  cmp_mode_r,
    output logic             cmp_swap_r,
    output logic      [1:0]  cmp_inv_r
);

    localparam int NB = gpas_pkg::NUM_BANKS;
    localparam int BW = gpas_pkg::BANK_W;

    // ========================================================
    // Address decode helpers
    function automatic logic [2:0] bank_of(input logic [4:0] a);
        bank_of = a[4:2];
    endfunction

    function automatic logic [1:0] kind_of(input logic [4:0] a);
        kind_of = a[1:0];
    endfunction

    function automatic logic bank_hit(input logic [4:0] a,
                                      input int b,
                                      input logic [1:0] k);
        bank_hit = (bank_of(a) == 3'(b)) && (kind_of(a) == k);
    endfunction

    // Analog channels still claimed for a given port field
    function automatic logic [4:0] analog_mask(input logic [3:0] f);
        logic [3:0] cnt;
        cnt = (f >= gpas_pkg::ANALOG_CHANNELS) ? 4'h0
            : 4'(gpas_pkg::ANALOG_CHANNELS - f);
        analog_mask = 5'h00;
        for (int i = 0; i < 5; i++) begin
            analog_mask[i] = (4'(i) < cnt);
        end
    endfunction

    // ========================================================
    // Configuration registers
    logic [3:0] conv_port_r;

    // Converter configuration, all analog after reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_port_r    <= gpas_pkg::CONV_PORT_RESET;
            conv_ref_cfg_r <= gpas_pkg::CONV_REF_RESET;
        end else if (reg_wr && reg_addr == gpas_pkg::ADDR_CONV_CFG) begin
            conv_port_r    <= reg_wdata[gpas_pkg::CONV_PORT_LSB +: 4];
            conv_ref_cfg_r <= reg_wdata[gpas_pkg::CONV_REF_LSB +: 2];
        end
    end

    // Comparator configuration
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_mode_r <= gpas_pkg::CMP_MODE_RESET;
            cmp_swap_r <= 1'b0;
            cmp_inv_r  <= 2'h0;
        end else if (reg_wr && reg_addr == gpas_pkg::ADDR_CMP_CFG) begin
            cmp_mode_r <= reg_wdata[gpas_pkg::CMP_MODE_LSB +: 3];
            cmp_swap_r <= reg_wdata[gpas_pkg::CMP_SWAP_BIT];
            cmp_inv_r  <= {reg_wdata[gpas_pkg::CMP_INV2_BIT],
                           reg_wdata[gpas_pkg::CMP_INV1_BIT]};
        end
    end

    // ========================================================
    // Pin ownership of the first bank
    logic [4:0] analog_nxt;
    logic [7:0] first_analog;
    logic       cmp_on;
    logic       cmp_drives_pin5;

    // Converter channels in order pin0..pin3, pin5
    assign analog_nxt = analog_mask(conv_port_r);
    assign cmp_on     = (cmp_mode_r != gpas_pkg::CMP_MODE_OFF);
    assign cmp_drives_pin5 = (cmp_mode_r == gpas_pkg::CMP_MODE_OUT2);

    // Pins whose digital input is disabled
    always_comb begin
        first_analog = 8'h00;
        first_analog[gpas_pkg::PIN0] = analog_nxt[0] | cmp_on;
        first_analog[gpas_pkg::PIN1] = analog_nxt[1];
        first_analog[gpas_pkg::PIN2] = analog_nxt[2];
        first_analog[gpas_pkg::PIN3] = analog_nxt[3] | cmp_on;
        first_analog[gpas_pkg::PIN5] = analog_nxt[4];
    end

    // Analog selection towards the converter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_sel_r <= 5'h1F;
        end else begin
            analog_sel_r <= analog_nxt;
        end
    end

    // ========================================================
    // Banks
    logic [BW-1:0] dir_w   [NB];
    logic [BW-1:0] hold_w  [NB];
    logic [BW-1:0] pins_rd [NB];

    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic [BW-1:0] impl;
        logic [BW-1:0] oe_nxt;
        logic [BW-1:0] out_nxt;
        logic [BW-1:0] in_now;

        assign impl = (b == 0) ? gpas_pkg::FIRST_BANK_MASK
                               : gpas_pkg::FULL_BANK_MASK;

        // Absent banks keep reset state and ignore writes
        gpas_bank u_bank (
            .ref_clk   (ref_clk),
            .reset_n   (reset_n),
            .present   (bank_present[b]),
            .impl_mask (impl),
            .wr_hold   (reg_wr && (bank_hit(reg_addr, b,
                            gpas_pkg::KIND_HOLD) ||
                        bank_hit(reg_addr, b,
                            gpas_pkg::KIND_PINS))),
            .wr_dir    (reg_wr && bank_hit(reg_addr, b,
                            gpas_pkg::KIND_DIR)),
            .wdata     (reg_wdata),
            .dir_r     (dir_w[b]),
            .hold_r    (hold_w[b])
        );

        // Driver enable follows direction, even on analog pins
        assign oe_nxt = bank_present[b] ? (~dir_w[b] & impl)
                                        : 8'h00;

        // Driven value: output-hold, or comparator on pin 5
        always_comb begin
            out_nxt = hold_w[b];
            if (b == 0 && cmp_drives_pin5) begin
                out_nxt[gpas_pkg::PIN5] = cmp_result[1]
                                        ^ cmp_inv_r[1];
            end
        end

        // Sampled levels; analog and absent pins read zero
        assign in_now = pad_in[b*BW +: BW] & impl
                      & ((b == 0) ? ~first_analog : 8'hFF);
        assign pins_rd[b] = bank_present[b] ? in_now : 8'h00;

        // Registered pad drive
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                pad_oe_r[b*BW +: BW]  <= 8'h00;
                pad_out_r[b*BW +: BW] <= gpas_pkg::HOLD_RESET;
            end else begin
                pad_oe_r[b*BW +: BW]  <= oe_nxt;
                pad_out_r[b*BW +: BW] <= out_nxt;
            end
        end
    end

    // ========================================================
    // Read path
    logic [7:0] rd_nxt;
    logic [2:0] rd_bank;

    assign rd_bank = bank_of(reg_addr);

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_nxt = 8'h00;
        if (reg_addr == gpas_pkg::ADDR_CONV_CFG) begin
            rd_nxt[gpas_pkg::CONV_PORT_LSB +: 4] = conv_port_r;
            rd_nxt[gpas_pkg::CONV_REF_LSB +: 2]  = conv_ref_cfg_r;
        end else if (reg_addr == gpas_pkg::ADDR_CMP_CFG) begin
            rd_nxt[gpas_pkg::CMP_MODE_LSB +: 3] = cmp_mode_r;
            rd_nxt[gpas_pkg::CMP_SWAP_BIT]      = cmp_swap_r;
            rd_nxt[gpas_pkg::CMP_INV1_BIT]      = cmp_inv_r[0];
            rd_nxt[gpas_pkg::CMP_INV2_BIT]      = cmp_inv_r[1];
            rd_nxt[gpas_pkg::CMP_RES1_BIT]  = cmp_result[0] ^ cmp_inv_r[0];
            rd_nxt[gpas_pkg::CMP_RES2_BIT]  = cmp_result[1] ^ cmp_inv_r[1];
        end else if (rd_bank < 3'(NB) && bank_present[rd_bank]) begin
            unique case (kind_of(reg_addr))
                gpas_pkg::KIND_PINS: rd_nxt = pins_rd[rd_bank];
                gpas_pkg::KIND_HOLD: rd_nxt = hold_w[rd_bank];
                gpas_pkg::KIND_DIR:  rd_nxt = dir_w[rd_bank]
                    & ((rd_bank == 3'h0) ? gpas_pkg::FIRST_BANK_MASK
                                         : gpas_pkg::FULL_BANK_MASK);
                default:             rd_nxt = 8'h00;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rd ? rd_nxt : 8'h00;
        end
    end

endmodule
`default_nettype wire

// ==== gpas_port_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Port-level checks of the general-purpose port
module gpas_port_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [4:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_r,
    // Straps, pins and analog selection
    input wire logic [4:0]  bank_present,
    input wire logic [39:0] pad_in,
    input wire logic [39:0] pad_out_r,
    input wire logic [39:0] pad_oe_r,
    input wire logic [4:0]  analog_sel_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata_r == 8'h00)
        else $error("read data not zero outside its slot");
    a_hold_write_drive: assert property (
        reg_wr && reg_addr == 5'h00 && bank_present[0]
        ##1 !(reg_wr && reg_addr < 5'h02)
        |=> pad_out_r[2:1] == $past(reg_wdata[2:1], 2))
        else $error("pin write did not reach the drive value");
    a_dir_gates_enable: assert property (
        reg_wr && reg_addr == 5'h02 && bank_present[0]
        ##1 !(reg_wr && reg_addr == 5'h02)
        |=> pad_oe_r[3:0] == ~$past(reg_wdata[3:0], 2))
        else $error("driver enable does not follow direction");
    a_unimpl_no_drive: assert property (
        pad_oe_r[7:6] == 2'h0 && !pad_oe_r[4])
        else $error("unimplemented first bank pin driven");
    a_reset_all_input: assert property (
        $rose(reset_n)
        |-> pad_oe_r == 40'h0 && analog_sel_r == 5'h1F)
        else $error("pins not input and analog after reset");
    a_absent_no_drive: assert property (
        !bank_present[4] [*2]
        |=> pad_oe_r[39:32] == 8'h00)
        else $error("absent bank drives its pins");
    // Selection one cycle later matches the claim used by the read
    a_analog_read_zero: assert property (
        reg_rd && reg_addr == 5'h00
        |=> !analog_sel_r[1] || reg_rdata_r[1] == 1'b0)
        else $error("analog pin read not zero");
    a_pin_read_level: assert property (
        reg_rd && reg_addr == 5'h00 && bank_present[0]
        |=> analog_sel_r[1] || reg_rdata_r[1] == $past(pad_in[1]))
        else $error("pin read differs from pin level");
endmodule

bind gpas_port gpas_port_props u_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .bank_present(bank_present),
    .pad_in(pad_in), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
    .analog_sel_r(analog_sel_r)
);
`default_nettype wire

// ==== gpas_pins_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Board wiring: pull-ups and optional outside drivers
module gpas_pins_model (
    // Design side
    input  wire logic [39:0] pad_out_r,
    input  wire logic [39:0] pad_oe_r,
    // Outside drivers
    input  wire logic [39:0] ext_en,
    input  wire logic [39:0] ext_val,
    // Resolved pin levels
    output logic      [39:0] pad_in
);
    // Own driver first, then outside driver, else pulled high
    assign pad_in = (pad_oe_r & pad_out_r) | (~pad_oe_r & ext_en & ext_val)
                  | (~pad_oe_r & ~ext_en);
endmodule
`default_nettype wire

// ==== gpas_port_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
// ============================================================
// Self-checking bench of the port block
module gpas_port_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [4:0]  bank_present = 5'h1F;
    logic [1:0]  cmp_result = 2'h0;
    logic [39:0] ext_en = 40'h0;
    logic [39:0] ext_val = 40'h0;
    logic [7:0]  reg_rdata_r;
    logic [39:0] pad_in;
    logic [39:0] pad_out_r;
    logic [39:0] pad_oe_r;
    logic [4:0]  analog_sel_r;
    logic [1:0]  conv_ref_cfg_r;
    logic [2:0]  cmp_mode_r;
    logic        cmp_swap_r;
    logic [1:0]  cmp_inv_r;
    int          n_errors = 0;
    int          samples_checked = 0;
    // Write address, data, read address, expected read
    logic [25:0] rows [10] = '{
        {5'h02, 8'hFF, 5'h02, 8'h2F}, {5'h02, 8'h00, 5'h02, 8'h00},
        {5'h01, 8'hFF, 5'h01, 8'h2F}, {5'h00, 8'h0A, 5'h01, 8'h0A},
        {5'h14, 8'h35, 5'h14, 8'h35}, {5'h15, 8'h0F, 5'h15, 8'h0F},
        {5'h10, 8'hA5, 5'h11, 8'hA5}, {5'h12, 8'h3C, 5'h12, 8'h3C},
        {5'h16, 8'hFF, 5'h16, 8'h00}, {5'h03, 8'hFF, 5'h03, 8'h00}};

    // Clock
    always #25 ref_clk = ~ref_clk;

    gpas_port uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .bank_present(bank_present), .pad_in(pad_in),
        .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
        .cmp_result(cmp_result), .analog_sel_r(analog_sel_r),
        .conv_ref_cfg_r(conv_ref_cfg_r), .cmp_mode_r(cmp_mode_r),
        .cmp_swap_r(cmp_swap_r), .cmp_inv_r(cmp_inv_r));

    gpas_pins_model u_pins (.pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // One register write
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // One register read, compared in the answer cycle
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        `CHK("read data", e, reg_rdata_r)
    endtask

    // Let pin outputs settle after a write
    task automatic pads;
        @(posedge ref_clk);
        #1;
    endtask

    // Reset held four cycles
    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask

    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #500000;
        n_errors++;
        summarize();
    end

    // Main sequence
    initial begin
        do_reset();
        for (int i = 0; i < 10; i++) begin
            wr(rows[i][25:21], rows[i][20:13]);
            rd(rows[i][12:8], rows[i][7:0]);
        end
        $display("table done");
        pads();
        `CHK("analog select", 5'h00, analog_sel_r)
        `CHK("reference cfg", 2'h3, conv_ref_cfg_r)
        `CHK("comparator mode", 3'h7, cmp_mode_r)
        `CHK("comparator swap", 1'b1, cmp_swap_r)
        `CHK("bank0 enable", 8'h2F, pad_oe_r[7:0])
        `CHK("bank0 drive", 4'hA, pad_out_r[3:0])
        `CHK("bank4 enable", 8'hC3, pad_oe_r[39:32])
        `CHK("bank4 drive", 8'hA5, pad_out_r[39:32])
        rd(5'h00, 8'h0A);
        wr(5'h02, 8'hFF);
        ext_en <= 40'hFF;
        rd(5'h00, 8'h00);
        rd(5'h01, 8'h0A);
        `CHK("bank0 enable", 8'h00, pad_oe_r[7:0])
        ext_en <= 40'h0;
        $display("drive done");
        wr(5'h01, 8'h00);
        wr(5'h02, 8'hFD);
        rd(5'h00, 8'h2D);
        wr(5'h02, 8'hFF);
        rd(5'h00, 8'h2F);
        $display("open drain done");
        cmp_result <= 2'h2;
        wr(5'h02, 8'hDF);
        wr(5'h15, 8'h06);
        pads();
        `CHK("pin5 compare", 1'b1, pad_out_r[5])
        `CHK("comparator mode", 3'h6, cmp_mode_r)
        rd(5'h00, 8'h26);
        rd(5'h15, 8'h86);
        wr(5'h15, 8'h26);
        pads();
        `CHK("pin5 compare", 1'b0, pad_out_r[5])
        `CHK("comparator inv", 2'h2, cmp_inv_r)
        wr(5'h15, 8'h07);
        rd(5'h00, 8'h0F);
        $display("comparator done");
        wr(5'h14, 8'h02);
        pads();
        `CHK("analog select", 5'h07, analog_sel_r)
        rd(5'h00, 8'h08);
        bank_present <= 5'h0F;
        wr(5'h11, 8'hFF);
        rd(5'h11, 8'h00);
        `CHK("bank4 enable", 8'h00, pad_oe_r[39:32])
        bank_present <= 5'h1F;
        cmp_result <= 2'h0;
        $display("absent bank done");
        do_reset();
        pads();
        `CHK("enables", 40'h0, pad_oe_r)
        `CHK("analog select", 5'h1F, analog_sel_r)
        rd(5'h00, 8'h00);
        rd(5'h02, 8'h2F);
        rd(5'h14, 8'h00);
        rd(5'h15, 8'h00);
        wr(5'h02, 8'h00);
        pads();
        `CHK("bank0 enable", 8'h2F, pad_oe_r[7:0])
        $display("reset done");
        summarize();
    end
endmodule
`default_nettype wire
